/* core/burst_step.sv */
/*
  next-beat generator for the two low address bits.
  assumes the caller holds the start offset and the current beat.
*/
`timescale 1ns/1ps
`default_nettype none
module burst_step (
  input wire logic interleave,
  input wire logic [1:0] start_off,
  input wire logic [1:0] beat,
  output logic [1:0] next_beat,
  output logic [1:0] next_off
);
  // beat counts 0..3; offset is start xor beat, or start plus beat
  assign next_beat = beat + 2'h1;
  assign next_off = interleave ? (start_off ^ next_beat) : (start_off + next_beat);
endmodule
`default_nettype wire

/* core/sram_ctl_front.sv */
/*
  control-input front end of a pipelined burst static memory: captures
  address, byte selects, write enable, advance/load and chip selects.
  assumes the host drives all pins synchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_ctl_front (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [sram_ctl_pkg::ADDR_W-1:0] addr,
  input wire logic byte_lane_a_write_n,
  input wire logic byte_lane_b_write_n,
  input wire logic byte_lane_c_write_n,
  input wire logic byte_lane_d_write_n,
  input wire logic write_n,
  input wire logic advance_or_load,
  input wire logic clock_qualify_n,
  input wire logic select_low_first,
  input wire logic select_high_second,
  input wire logic select_low_third,
  input wire logic burst_order,
  input wire logic out_enable_n,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] wdata,
  output logic [sram_ctl_pkg::ADDR_W-1:0] mem_addr,
  output logic [sram_ctl_pkg::LANES-1:0] mem_lane_we,
  output logic mem_write,
  output logic mem_read,
  output logic [sram_ctl_pkg::DATA_W-1:0] mem_wdata,
  output logic selected,
  output logic data_drive_en
);

  // pin decode for this edge
  logic take;
  logic load_req;
  logic step_req;
  logic sel_now;
  logic wr_now;
  logic [sram_ctl_pkg::LANES-1:0] lanes_pins;
  logic [sram_ctl_pkg::LANES-1:0] lanes_now;
  logic active;

  // captured access state and its next values
  sram_ctl_pkg::op_t op_r;
  sram_ctl_pkg::op_t op_nxt;
  logic sel_r;
  logic sel_nxt;
  logic first_r;
  logic first_nxt;
  logic [sram_ctl_pkg::ADDR_W-1:0] base_r;
  logic [sram_ctl_pkg::ADDR_W-1:0] base_nxt;
  logic [1:0] start_r;
  logic [1:0] start_nxt;
  logic [1:0] beat_r;
  logic [1:0] beat_nxt;
  logic [1:0] off_r;
  logic [1:0] off_nxt;
  logic [sram_ctl_pkg::LANES-1:0] lane_we_r;
  logic [sram_ctl_pkg::LANES-1:0] lane_we_nxt;
  logic [sram_ctl_pkg::DATA_W-1:0] wdata_r;
  logic [sram_ctl_pkg::DATA_W-1:0] wdata_nxt;

  // next burst position from the helper
  logic [1:0] step_beat;
  logic [1:0] step_off;

  // qualifier gates every capture; a high level makes the edge invisible
  assign take = ~clock_qualify_n;
  assign load_req = take & ~advance_or_load;
  assign step_req = take & advance_or_load;

  // all three selects must sit at their active levels together
  assign sel_now = ~select_low_first & select_high_second & ~select_low_third;

  // write enable only counts on a qualified edge
  assign wr_now = ~write_n;

  // lane a in bit 0; each lane covers its byte and its parity bit
  assign lanes_pins = {byte_lane_d_write_n, byte_lane_c_write_n, byte_lane_b_write_n, byte_lane_a_write_n};
  assign lanes_now = ~lanes_pins;

  // a burst may only walk while an access is open
  assign active = (op_r == sram_ctl_pkg::OP_READ) | (op_r == sram_ctl_pkg::OP_WRITE);

  // offset walker; strap picks interleaved or linear order
  burst_step step_u (
    .interleave(burst_order),
    .start_off(start_r),
    .beat(beat_r),
    .next_beat(step_beat),
    .next_off(step_off)
  );

  // write data captured on every qualified edge, held through a stall
  assign wdata_nxt = take ? wdata : wdata_r;

  // next state: a load restarts, an advance walks the burst, a stall keeps all
  always_comb begin
    op_nxt = op_r;
    sel_nxt = sel_r;
    first_nxt = first_r;
    base_nxt = base_r;
    start_nxt = start_r;
    beat_nxt = beat_r;
    off_nxt = off_r;
    lane_we_nxt = lane_we_r;
    if (load_req) begin
      base_nxt = addr;
      start_nxt = addr[1:0];
      beat_nxt = sram_ctl_pkg::BURST_RST;
      off_nxt = addr[1:0];
      sel_nxt = sel_now;
      first_nxt = sel_now & ~sel_r;
      if (!sel_now) begin
        op_nxt = sram_ctl_pkg::OP_IDLE;
        lane_we_nxt = {sram_ctl_pkg::LANES{1'b0}};
      end else if (wr_now) begin
        op_nxt = sram_ctl_pkg::OP_WRITE;
        lane_we_nxt = lanes_now;
      end else begin
        op_nxt = sram_ctl_pkg::OP_READ;
        lane_we_nxt = {sram_ctl_pkg::LANES{1'b0}};
      end
    end else if (step_req) begin
      first_nxt = 1'b0;
      case (op_r)
        sram_ctl_pkg::OP_READ: begin
          beat_nxt = step_beat;
          off_nxt = step_off;
          lane_we_nxt = {sram_ctl_pkg::LANES{1'b0}};
        end
        sram_ctl_pkg::OP_WRITE: begin
          beat_nxt = step_beat;
          off_nxt = step_off;
          lane_we_nxt = lanes_now;
        end
        default: begin
          // an advance with no open access is a no-op
          lane_we_nxt = {sram_ctl_pkg::LANES{1'b0}};
        end
      endcase
    end
  end

  // access control state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      op_r <= sram_ctl_pkg::OP_IDLE;
      sel_r <= 1'b0;
      first_r <= 1'b0;
      lane_we_r <= {sram_ctl_pkg::LANES{1'b0}};
    end else begin
      op_r <= op_nxt;
      sel_r <= sel_nxt;
      first_r <= first_nxt;
      lane_we_r <= lane_we_nxt;
    end
  end

  // address and data capture
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      base_r <= sram_ctl_pkg::ADDR_RST;
      start_r <= sram_ctl_pkg::BURST_RST;
      beat_r <= sram_ctl_pkg::BURST_RST;
      off_r <= sram_ctl_pkg::BURST_RST;
      wdata_r <= {sram_ctl_pkg::DATA_W{1'b0}};
    end else begin
      base_r <= base_nxt;
      start_r <= start_nxt;
      beat_r <= beat_nxt;
      off_r <= off_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // outputs straight from flops; the burst only touches the low two bits
  assign mem_addr = {base_r[sram_ctl_pkg::ADDR_W-1:2], off_r};
  assign mem_lane_we = lane_we_r;
  assign mem_write = (op_r == sram_ctl_pkg::OP_WRITE);
  assign mem_read = (op_r == sram_ctl_pkg::OP_READ);
  assign mem_wdata = wdata_r;
  assign selected = sel_r;

  // drive only on a read past its first selected cycle; async enable gates last
  assign data_drive_en = mem_read & ~first_r & ~out_enable_n;

  // checks on the decode and the captured state
  default clocking cb_core @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_stall;
    clock_qualify_n;
  endsequence

  sequence s_load_sel;
    load_req && sel_now;
  endsequence

  sequence s_step_busy;
    step_req && active;
  endsequence

  a_stall_holds_data: assert property (s_stall |=> $stable(mem_addr) && $stable(mem_wdata))
    else $error("stalled edge changed address or data");

  a_stall_keeps_select: assert property (s_stall |=> $stable(selected) && $stable(mem_read))
    else $error("stalled edge changed the selection");

  a_desel_first: assert property (load_req && select_low_first |=> !selected)
    else $error("first select high did not deselect");

  a_desel_second: assert property (load_req && !select_high_second |=> !selected)
    else $error("second select low did not deselect");

  a_select_all: assert property (s_load_sel |=> selected)
    else $error("all selects active but not selected");

  a_load_address: assert property (load_req |=> mem_addr == $past(addr))
    else $error("loaded address not presented");

  a_write_needs_enable: assert property (s_load_sel ##0 write_n |=> !mem_write && mem_lane_we == 4'h0)
    else $error("byte lanes acted without write enable");

  a_lanes_on_write: assert property (s_load_sel ##0 !write_n |=> mem_lane_we == ~$past(lanes_pins))
    else $error("byte lanes differ from their selects");

  a_step_low_bits: assert property (s_step_busy |=> mem_addr[1:0] != $past(mem_addr[1:0]))
    else $error("advance did not move the burst offset");

  a_step_high_bits: assert property (s_step_busy |=> $stable(mem_addr[sram_ctl_pkg::ADDR_W-1:2]))
    else $error("burst step touched upper address bits");

  a_drive_masked: assert property (mem_write || !selected |-> !data_drive_en)
    else $error("data driven on write or while deselected");
endmodule
`default_nettype wire

/* core/sram_ctl_pkg.sv */
/*
  constants for the burst memory control-input front end.
  assumes one rising-edge clock and synchronous host pins.
*/
package sram_ctl_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [1:0] BURST_RST = 2'h0;
  // access types held in the capture stage
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b11,
    OP_CONT = 2'b10
  } op_t;
endpackage

/* test/sram_host.sv */
/* random host pins for the front end.
   assumes bench sets hold and desel. */
`timescale 1ns/1ps
`default_nettype none
module sram_host (
  input wire logic core_clk,
  input wire logic hold,
  input wire logic desel,
  output logic [17:0] a,
  output logic [11:0] c,
  output logic [35:0] d
);
  int seed = 18217;
  // fresh pins each falling edge
  always @(negedge core_clk) begin
    a <= 18'($random(seed));
    d <= 36'($random(seed));
    c <= 12'($random(seed)); // write enable and every other control pin random
    if (hold) c[11] <= 1'b1;
    // deselect by loads so the next access starts fresh
    if (desel) begin
      c[6] <= 1'b1;
      c[5] <= 1'b0;
      c[11] <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* test/test_sram_ctl_front.sv */
/* bench for the front end: stall and deselect.
   assumes sram_host drives the pins. */
`timescale 1ns/1ps
`default_nettype none
module test_sram_ctl_front;
  logic core_clk = 0, rstn = 0, hold = 0, desel = 0, mode = 1;
  // reference state kept from the pin rules alone
  logic e_sel = 0, e_wr = 0, e_rd = 0, e_first = 0;
  logic [17:0] e_base = 0;
  logic [1:0] e_start = 0, e_beat = 0;
  logic [3:0] e_lanes = 0;
  logic [35:0] e_wdata = 0;
  int fail_count = 0, comparisons = 0, cyc = 0;
  logic [17:0] a;
  logic [11:0] c;
  logic [35:0] d;
  logic [61:0] o, snap;
  sram_host host_u (.core_clk(core_clk), .hold(hold), .desel(desel), .a(a), .c(c), .d(d));
  sram_ctl_front dut_u (.core_clk(core_clk), .rstn(rstn), .addr(a), .byte_lane_a_write_n(c[0]),
    .byte_lane_b_write_n(c[1]), .byte_lane_c_write_n(c[2]), .byte_lane_d_write_n(c[3]),
    .write_n(c[4]), .advance_or_load(c[5]), .clock_qualify_n(c[11]), .select_low_first(c[6]),
    .select_high_second(c[7]), .select_low_third(c[8]), .burst_order(mode), .out_enable_n(c[10]),
    .wdata(d), .mem_addr(o[61:44]), .mem_lane_we(o[43:40]), .mem_write(o[39]), .mem_read(o[38]),
    .mem_wdata(o[37:2]), .selected(o[1]), .data_drive_en(o[0]));
  initial forever #10 core_clk = ~core_clk;
  // offset of a beat within its aligned group of four
  function automatic logic [1:0] burst_off(input logic inter, input logic [1:0] start, input logic [1:0] beat);
    return inter ? (start ^ beat) : 2'(start + beat);
  endfunction
  function automatic logic picked(input logic [11:0] pins);
    return !pins[6] && pins[7] && !pins[8];
  endfunction
  // reference model, stepped only on qualified edges
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {e_sel, e_wr, e_rd, e_first, e_base, e_start, e_beat, e_lanes, e_wdata} <= '0;
    end else if (!c[11]) begin
      e_wdata <= d;
      if (!c[5]) begin
        e_first <= picked(c) && !e_sel;
        e_sel <= picked(c);
        e_wr <= picked(c) && !c[4];
        e_rd <= picked(c) && c[4];
        e_base <= a;
        e_start <= a[1:0];
        e_beat <= 2'h0;
        e_lanes <= (picked(c) && !c[4]) ? ~c[3:0] : 4'h0;
      end else begin
        e_first <= 1'b0;
        if (e_wr || e_rd) e_beat <= e_beat + 2'h1;
        e_lanes <= e_wr ? ~c[3:0] : 4'h0;
      end
    end
  end
  // every output against the model while out of reset
  always @(negedge core_clk) begin
    if (rstn) begin
      chk(o[61:44] === {e_base[17:2], burst_off(mode, e_start, e_beat)});
      chk(o[43:38] === {e_lanes, e_wr, e_rd});
      chk(o[37:2] === e_wdata);
      chk(o[1:0] === {e_sel, e_rd && !e_first && !c[10]});
    end
  end
  task chk(input logic ok);
    comparisons++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("Error %0t output mismatch", $time);
    end
  endtask
  task stop_test;
    $display("fails %0d of %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      stop_test();
    end
  end
  // stall keeps state, deselect masks drive
  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1;
    for (int pass = 0; pass < 2; pass++) begin
      repeat (20) begin
        repeat (20) @(negedge core_clk);
        hold = 1;
        repeat (3) @(negedge core_clk);
        snap = o;
        repeat (4) @(negedge core_clk) chk(o[61:1] === snap[61:1]);
        hold = 0;
        desel = 1;
        repeat (6) @(negedge core_clk);
        chk(o[1:0] === 2'h0);
        desel = 0;
      end
      if (pass == 0) begin
        // mid-run reset; the strap only moves while held in reset
        rstn = 0;
        mode = 0;
        @(negedge core_clk);
        chk(o[39:38] === 2'h0 && o[1:0] === 2'h0);
        repeat (7) @(negedge core_clk);
        rstn = 1;
      end
    end
    stop_test();
  end
endmodule
`default_nettype wire
